// file: common/aocs_regs.svh
/*
  Register offsets, reset values and classification thresholds of the
  current output channel status block.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`ifndef AOCS_REGS_SVH
`define AOCS_REGS_SVH

// ============================================================
// register byte offsets
`define AOCS_OFF_DEMAND 8'h00
`define AOCS_OFF_GUARD 8'h04
`define AOCS_OFF_CTRL 8'h08
`define AOCS_OFF_COMPACT 8'h0c
`define AOCS_OFF_FULL0 8'h10
`define AOCS_OFF_FULL1 8'h14

// ============================================================
// field positions and reset values
`define AOCS_CTRL_CYCLE_BIT 0
`define AOCS_RST_DEMAND 16'h0000
`define AOCS_RST_GUARD 7'h01
`define AOCS_GUARD_MAX 7'h64
`define AOCS_RST_STATE 8'h02

// ============================================================
// channel state codes
`define AOCS_ST_NOFIELD 8'h01
`define AOCS_ST_OFF 8'h02
`define AOCS_ST_NOLOAD 8'h03
`define AOCS_ST_ON 8'h04
`define AOCS_ST_COMPLY 8'h05
`define AOCS_ST_REVERSE 8'h06
`define AOCS_ST_FAULTED 8'h07

// ============================================================
// thresholds: counts are 256 per mA, voltages in mV
`define AOCS_COUNT_4MA 18'sh00400
`define AOCS_COUNT_MAX 18'sh01800
`define AOCS_COUNT_0P4MA 18'sh00066
`define AOCS_COUNT_0P2MA 18'sh00033
`define AOCS_MV_NOLOAD 18'sh003e8
`define AOCS_MV_REVERSE (-18'sh003e8)
`define AOCS_MV_FIELD 16'h4650
`define AOCS_GUARD_SCALE 25'h0000200
`define AOCS_GUARD_DIV 25'h000000a

`endif

// file: common/aocs_pkg.sv
/*
  Types shared by the current output channel status block.
  Assumes the constants of aocs_regs.svh alongside.
*/
package aocs_pkg;

    // ============================================================
    // sequencer of one application cycle
    typedef enum logic [1:0]
    {
        AOCS_IDLE,
        AOCS_EVAL
    } aocs_seq_e;

    typedef logic [7:0] aocs_code_t;

endpackage : aocs_pkg

// file: hdl/aocs_classify.sv
/*
  Combinational classifier of one current output channel.
  Assumes its inputs are held stable by registers in the parent.
*/
`timescale 1ns/10ps
`include "aocs_regs.svh"

module aocs_classify
    import aocs_pkg::*;
(
    // snapshot of demand and measurements
    input wire logic signed [15:0] demand_value_i,
    input wire logic signed [15:0] meas_count_i,
    input wire logic signed [15:0] term_mv_i,
    input wire logic [15:0] field_mv_i,
    input wire logic [6:0] guard_pct_i,
    input wire logic diag_fault_i,
    // classification result
    output aocs_code_t state_code_o,
    output logic line_fault_o,
    output logic discrepancy_o,
    output logic channel_fault_o,
    output logic signed [15:0] report_mv_o,
    output logic signed [15:0] report_count_o,
    output logic [15:0] demand_count_o
);

    logic signed [17:0] dem_raw;
    logic signed [17:0] dem_count;
    logic signed [17:0] meas18;
    logic signed [17:0] mv18;
    logic signed [17:0] diff;
    logic [17:0] adiff;
    logic [24:0] lhs;
    logic [24:0] rhs;
    logic gap;

    // ============================================================
    // demand to counts, then state priority
    always_comb
    begin
        dem_raw = 18'(demand_value_i) + `AOCS_COUNT_4MA;
        if (dem_raw < 18'sh0)
            dem_count = 18'sh0;
        else if (dem_raw > `AOCS_COUNT_MAX)
            dem_count = `AOCS_COUNT_MAX;
        else
            dem_count = dem_raw;
        meas18 = 18'(meas_count_i);
        mv18 = 18'(term_mv_i);
        diff = meas18 - dem_count;
        adiff = (diff < 18'sh0) ? 18'($unsigned(-diff)) : 18'($unsigned(diff));
        // compare |diff| against band without a divider
        lhs = 25'(adiff) * `AOCS_GUARD_DIV;
        rhs = 25'(guard_pct_i) * `AOCS_GUARD_SCALE;
        gap = (meas18 + `AOCS_COUNT_0P2MA) < dem_count;
        if (diag_fault_i)
            state_code_o = `AOCS_ST_FAULTED; // fault seen
        else if (mv18 < `AOCS_MV_REVERSE)
            state_code_o = `AOCS_ST_REVERSE;
        else if (field_mv_i <= `AOCS_MV_FIELD && dem_count < `AOCS_COUNT_0P4MA)
            state_code_o = `AOCS_ST_NOFIELD;
        else if (dem_count > `AOCS_COUNT_0P4MA && meas18 < `AOCS_COUNT_0P2MA
                 && mv18 < `AOCS_MV_NOLOAD)
            state_code_o = `AOCS_ST_NOLOAD;
        else if (dem_count > `AOCS_COUNT_0P4MA && gap)
            state_code_o = `AOCS_ST_COMPLY;
        else if (meas18 < `AOCS_COUNT_0P4MA)
            state_code_o = `AOCS_ST_OFF;
        else
            state_code_o = `AOCS_ST_ON;
        line_fault_o = (state_code_o == `AOCS_ST_NOFIELD)
                    || (state_code_o == `AOCS_ST_NOLOAD)
                    || (state_code_o == `AOCS_ST_COMPLY)
                    || (state_code_o == `AOCS_ST_REVERSE)
                    || (state_code_o == `AOCS_ST_FAULTED);
        channel_fault_o = (state_code_o == `AOCS_ST_FAULTED);
        discrepancy_o = channel_fault_o || (lhs > rhs);
        report_mv_o = term_mv_i;
        if (state_code_o == `AOCS_ST_NOFIELD || channel_fault_o)
            report_mv_o = 16'sh0;
        report_count_o = channel_fault_o ? 16'sh0 : meas_count_i;
        demand_count_o = 16'($unsigned(dem_count));
    end

endmodule : aocs_classify

// file: hdl/aocs_top.sv
/*
  Status and diagnosis top of one 4-20 mA current output channel:
  Wishbone register file, one-shot application cycle, registered views.
  Assumes measurement inputs are synchronous to clk_i and held steady
  by the converter front end while a cycle is requested.
*/
// Contract
// - demand 0 to 100 percent maps linearly to 4 to 20 mA.
// - line fault true for state codes 1, 3, 5, 6, 7.
// - discrepancy when loop and demand differ beyond guard band.
// - channel fault true only for electronics fault, state 7.
// - terminal voltage reported as signed millivolts.
// - loop current reported as signed count, 256 per mA.
// - state is an unsigned byte taking values 1 to 7.
// - state 1 when field supply at most 18 V, demand under 0.4 mA.
// - in state 1 reported voltage is zero.
// - state 2 when count below 102.
// - state 3 when demand above 0.4 mA, count under 51, under 1 V.
// - state 4 when count at least 102 and no fault.
// - state 5 when demand above 102 counts but unreachable by 0.2 mA.
// - in state 5 keep driving, no fail-safe, no channel fault.
// - state 6 when terminal voltage below minus 1000 mV.
// - a known diagnosed fault marks the channel faulted.
// - faulted gives state 7, all flags true, voltage and count zero.
// - compact view of demand and two flags; full view of all. The full view words hold state, three flags, voltage and count, but no demand.
// - guard band 0 to 100 percent, default 1 percent.
// - outputs and status update once per application cycle.
`timescale 1ns/10ps
`include "aocs_regs.svh"

module aocs_top
    import aocs_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // loop measurements and diagnostics
    input wire logic signed [15:0] meas_count_i,
    input wire logic signed [15:0] term_mv_i,
    input wire logic [15:0] field_mv_i,
    input wire logic diag_fault_i,
    // published channel status
    output logic [15:0] demand_value_o,
    output logic line_fault_flag_o,
    output logic discrepancy_flag_o,
    output logic channel_fault_flag_o,
    output logic signed [15:0] term_mv_o,
    output logic signed [15:0] raw_current_count_o,
    output logic [7:0] channel_state_code_o,
    output logic [15:0] drive_count_o,
    output logic status_valid_o
);

    // ============================================================
    // declarations

    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [15:0] demand_q;
    logic [15:0] demand_d;
    logic [6:0] guard_q;
    logic [6:0] guard_d;
    logic req;
    logic wr;
    logic go;

    aocs_seq_e seq_q;
    aocs_seq_e seq_d;
    logic [15:0] sdem_q;
    logic [15:0] sdem_d;
    logic [15:0] smeas_q;
    logic [15:0] smeas_d;
    logic [15:0] smv_q;
    logic [15:0] smv_d;
    logic [15:0] sfield_q;
    logic [15:0] sfield_d;
    logic [6:0] sguard_q;
    logic [6:0] sguard_d;
    logic sdiag_q;
    logic sdiag_d;

    aocs_code_t c_state;
    logic c_lf;
    logic c_dis;
    logic c_chf;
    logic signed [15:0] c_mv;
    logic signed [15:0] c_count;
    logic [15:0] c_dem_count;

    logic [15:0] odem_q;
    logic [15:0] odem_d;
    logic olf_q;
    logic olf_d;
    logic odis_q;
    logic odis_d;
    logic ochf_q;
    logic ochf_d;
    logic [15:0] omv_q;
    logic [15:0] omv_d;
    logic [15:0] ocount_q;
    logic [15:0] ocount_d;
    logic [7:0] ostate_q;
    logic [7:0] ostate_d;
    logic [15:0] odrive_q;
    logic [15:0] odrive_d;
    logic ovalid_q;
    logic ovalid_d;

    // ============================================================
    // wishbone slave and software registers

    // a request is answered once; ack drops the cycle after it rose
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i;
    // only the low byte lane carries the cycle strobe
    assign go = wr && (wb_adr_i == `AOCS_OFF_CTRL) && wb_sel_i[0]
             && wb_dat_i[`AOCS_CTRL_CYCLE_BIT];

    // bus next values: write decode and read mux
    always_comb
    begin
        ack_d = req;
        demand_d = demand_q;
        guard_d = guard_q;
        rdat_d = rdat_q;
        if (wr && wb_adr_i == `AOCS_OFF_DEMAND)
        begin
            if (wb_sel_i[0])
                demand_d[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
                demand_d[15:8] = wb_dat_i[15:8];
        end
        // guard band saturates at 100 percent
        if (wr && wb_adr_i == `AOCS_OFF_GUARD && wb_sel_i[0])
        begin
            if (wb_dat_i[7:0] > 8'(`AOCS_GUARD_MAX))
                guard_d = `AOCS_GUARD_MAX;
            else
                guard_d = wb_dat_i[6:0];
        end
        if (req)
        begin
            case (wb_adr_i)
                `AOCS_OFF_DEMAND: rdat_d = {16'h0000, demand_q};
                `AOCS_OFF_GUARD: rdat_d = {25'h0000000, guard_q};
                // compact view, demand plus two flags
                `AOCS_OFF_COMPACT: rdat_d = {14'h0000, odis_q, olf_q, odem_q};
                // full view adds fault, state, voltage, count
                `AOCS_OFF_FULL0: rdat_d = {16'h0000, ostate_q, 5'h00,
                                           ochf_q, odis_q, olf_q};
                `AOCS_OFF_FULL1: rdat_d = {ocount_q, omv_q};
                // control and unmapped words read as zero
                default: rdat_d = 32'h00000000;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
            demand_q <= `AOCS_RST_DEMAND;
            guard_q <= `AOCS_RST_GUARD;
        end
        else
        begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            demand_q <= demand_d;
            guard_q <= guard_d;
        end
    end

    // ============================================================
    // application cycle sequencer and input snapshot

    // snapshot taken at the strobe so the evaluation sees one instant
    always_comb
    begin
        seq_d = seq_q;
        sdem_d = sdem_q;
        smeas_d = smeas_q;
        smv_d = smv_q;
        sfield_d = sfield_q;
        sguard_d = sguard_q;
        sdiag_d = sdiag_q;
        case (seq_q)
            AOCS_IDLE:
            begin
                if (go)
                begin
                    seq_d = AOCS_EVAL;
                    sdem_d = demand_q;
                    smeas_d = meas_count_i;
                    smv_d = term_mv_i;
                    sfield_d = field_mv_i;
                    sguard_d = guard_q;
                    sdiag_d = diag_fault_i;
                end
            end
            // a strobe arriving here is dropped, the cycle is busy
            AOCS_EVAL: seq_d = AOCS_IDLE;
            default: seq_d = AOCS_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seq_q <= AOCS_IDLE;
            sdem_q <= 16'h0000;
            smeas_q <= 16'h0000;
            smv_q <= 16'h0000;
            sfield_q <= 16'h0000;
            sguard_q <= `AOCS_RST_GUARD;
            sdiag_q <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            sdem_q <= sdem_d;
            smeas_q <= smeas_d;
            smv_q <= smv_d;
            sfield_q <= sfield_d;
            sguard_q <= sguard_d;
            sdiag_q <= sdiag_d;
        end
    end

    // ============================================================
    // classification of the snapshot

    aocs_classify u_classify
    (
        .demand_value_i (sdem_q),
        .meas_count_i (smeas_q),
        .term_mv_i (smv_q),
        .field_mv_i (sfield_q),
        .guard_pct_i (sguard_q),
        .diag_fault_i (sdiag_q),
        .state_code_o (c_state),
        .line_fault_o (c_lf),
        .discrepancy_o (c_dis),
        .channel_fault_o (c_chf),
        .report_mv_o (c_mv),
        .report_count_o (c_count),
        .demand_count_o (c_dem_count)
    );

    // ============================================================
    // published status and loop drive

    // views change only in the evaluation cycle, never mid-cycle
    always_comb
    begin
        odem_d = odem_q;
        olf_d = olf_q;
        odis_d = odis_q;
        ochf_d = ochf_q;
        omv_d = omv_q;
        ocount_d = ocount_q;
        ostate_d = ostate_q;
        odrive_d = odrive_q;
        ovalid_d = 1'b0;
        if (seq_q == AOCS_EVAL)
        begin
            odem_d = sdem_q;
            olf_d = c_lf;
            odis_d = c_dis;
            ochf_d = c_chf;
            omv_d = c_mv;
            ocount_d = c_count;
            // code from the 1 to 7 set only
            ostate_d = c_state;
            ovalid_d = 1'b1;
            odrive_d = c_chf ? 16'h0000 : c_dem_count;
        end
    end

    // status registers, reset to an idle off channel
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            odem_q <= 16'h0000;
            olf_q <= 1'b0;
            odis_q <= 1'b0;
            ochf_q <= 1'b0;
            omv_q <= 16'h0000;
            ocount_q <= 16'h0000;
            ostate_q <= `AOCS_RST_STATE;
            odrive_q <= 16'h0000;
            ovalid_q <= 1'b0;
        end
        else
        begin
            odem_q <= odem_d;
            olf_q <= olf_d;
            odis_q <= odis_d;
            ochf_q <= ochf_d;
            omv_q <= omv_d;
            ocount_q <= ocount_d;
            ostate_q <= ostate_d;
            odrive_q <= odrive_d;
            ovalid_q <= ovalid_d;
        end
    end

    // every output straight from a flip-flop
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign demand_value_o = odem_q;
    assign line_fault_flag_o = olf_q;
    assign discrepancy_flag_o = odis_q;
    assign channel_fault_flag_o = ochf_q;
    assign term_mv_o = omv_q;
    assign raw_current_count_o = ocount_q;
    assign channel_state_code_o = ostate_q;
    assign drive_count_o = odrive_q;
    assign status_valid_o = ovalid_q;

    // ============================================================
    // assertions

    property p_lf_codes;
        @(posedge clk_i) disable iff (rst_i)
        olf_q == (ostate_q == 8'h01 || ostate_q == 8'h03 || ostate_q == 8'h05
                  || ostate_q == 8'h06 || ostate_q == 8'h07);
    endproperty
    a_lf_codes: assert property (p_lf_codes)
        else $error("line fault disagrees with state code");

    property p_chf_state;
        @(posedge clk_i) disable iff (rst_i)
        ochf_q == (ostate_q == 8'h07);
    endproperty
    a_chf_state: assert property (p_chf_state)
        else $error("channel fault without state 7");

    property p_code_range;
        @(posedge clk_i) disable iff (rst_i)
        ostate_q >= 8'h01 && ostate_q <= 8'h07;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("state code outside 1 to 7");

    property p_nofield_mv;
        @(posedge clk_i) disable iff (rst_i)
        ostate_q == 8'h01 |-> omv_q == 16'h0000;
    endproperty
    a_nofield_mv: assert property (p_nofield_mv)
        else $error("voltage not blanked in state 1");

    property p_fault_safe;
        @(posedge clk_i) disable iff (rst_i)
        ostate_q == 8'h07 |-> olf_q && odis_q && omv_q == 16'h0000
                              && ocount_q == 16'h0000 && odrive_q == 16'h0000;
    endproperty
    a_fault_safe: assert property (p_fault_safe)
        else $error("faulted channel shows unsafe values");

    property p_cycle_once;
        @(posedge clk_i) disable iff (rst_i)
        (seq_q == AOCS_IDLE && go) |-> !ovalid_q ##2 ovalid_q ##1 !ovalid_q;
    endproperty
    a_cycle_once: assert property (p_cycle_once)
        else $error("cycle strobe did not publish exactly once");

    property p_change_at_publish;
        @(posedge clk_i) disable iff (rst_i)
        ($changed(ostate_q) || $changed(ocount_q)) |-> ovalid_q;
    endproperty
    a_change_at_publish: assert property (p_change_at_publish)
        else $error("status changed outside a cycle");

    property p_comply_drive;
        @(posedge clk_i) disable iff (rst_i)
        ostate_q == 8'h05 |-> !ochf_q && odrive_q > 16'h0066;
    endproperty
    a_comply_drive: assert property (p_comply_drive)
        else $error("compliance state stopped driving");

    property p_guard_range;
        @(posedge clk_i) disable iff (rst_i)
        guard_q <= 7'h64;
    endproperty
    a_guard_range: assert property (p_guard_range)
        else $error("guard band above 100 percent");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

endmodule : aocs_top

// file: tb/aocs_loop_model.sv
/*
  Field loop model: wiring and load of one current output channel.
  Assumes the drive command counts 256 per mA, as the block reports it.
*/
`timescale 1ns/10ps

module aocs_loop_model
(
    // drive command and wiring mode
    input wire logic [15:0] drive_i,
    input wire logic [2:0] mode_i,
    // loop measurements
    output logic signed [15:0] count_o,
    output logic signed [15:0] mv_o,
    output logic [15:0] field_o
);
    // ============================================================
    // load per mode; a starved loop sags 52 counts, just past 0.2 mA
    always_comb
    begin
        field_o = 16'h5dc0;
        mv_o = 16'sh2ee0;
        count_o = drive_i;
        case (mode_i)
            3'h1: {count_o, mv_o} = {16'h0000, 16'h01f4}; // open loop
            3'h2: {count_o, mv_o} = {16'h0000, 16'hfc17}; // reversed, -1001 mV
            3'h3: {count_o, mv_o, field_o} = {16'h0000, 16'h012c, 16'h4650}; // 18 V
            3'h4: count_o = drive_i - 16'h0034; // compliance limit
            default: ;
        endcase
    end
endmodule : aocs_loop_model

// file: tb/tb_top.sv
/*
  Self-checking bench of the channel status block.
  Assumes the loop model stands at the field side and a bus master here.
*/
`timescale 1ns/10ps
`include "aocs_regs.svh"

module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, dg = 1'b0, ack, vld, lf, ds, cf;
    logic [7:0] adr = 8'h00, st;
    logic [3:0] sel = 4'hf;
    logic [31:0] wd = 32'h0, rd, dat;
    logic [2:0] mode = 3'h0;
    logic [15:0] dmd, dmo, drv, fld;
    logic signed [15:0] cnt, mv, mcnt, mmv;
    int err_total = 0;
    int n_checks = 0;
    int ticks = 0;

    // ============================================================
    // clock and hang guard
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        ticks++;
        if (ticks == 4000)
        begin
            err_total++;
            conclude();
        end
    end

    aocs_loop_model loop (.drive_i(drv), .mode_i(mode), .count_o(mcnt), .mv_o(mmv),
        .field_o(fld));

    aocs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat),
        .wb_ack_o(ack), .meas_count_i(mcnt), .term_mv_i(mmv), .field_mv_i(fld),
        .diag_fault_i(dg), .demand_value_o(dmo), .line_fault_flag_o(lf),
        .discrepancy_flag_o(ds), .channel_fault_flag_o(cf), .term_mv_o(mv),
        .raw_current_count_o(cnt), .channel_state_code_o(st), .drive_count_o(drv),
        .status_valid_o(vld));

    // ============================================================
    // shared helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // classic single cycle; read data taken at the ack edge only
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
        // no cycle limit here: only the bench timeout ends a wait
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rd = dat;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic cycle();
        int n;
        n = 0;
        wb(1'b1, `AOCS_OFF_CTRL, 32'h1);
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (vld !== 1'b1 && n < 8);
        chk("valid", n, 1);
        @(posedge clk_i);
        chk("pulse", vld, 1'b0);
    endtask : cycle

    // two cycles so the loop settles on the new drive
    task automatic run(input logic [15:0] dm, input logic [2:0] md, input logic df);
        dmd = dm;
        wb(1'b1, `AOCS_OFF_DEMAND, {16'h0, dm});
        mode <= md;
        dg <= df;
        cycle();
        cycle();
    endtask : run

    task automatic verify(input string nm, input logic [7:0] s, input logic [2:0] fl,
        input logic signed [15:0] v, input logic signed [15:0] c, input logic [15:0] dv);
        chk("state", st, s);
        chk("flags", {cf, ds, lf}, fl);
        chk("mv", mv, v);
        chk("count", cnt, c);
        chk("drive", drv, dv);
        chk("demand", dmo, dmd);
        wb(1'b0, `AOCS_OFF_FULL0, 32'h0);
        chk("full0", rd, {16'h0, s, 5'h0, fl});
        wb(1'b0, `AOCS_OFF_FULL1, 32'h0);
        chk("full1", rd, {c, v});
        wb(1'b0, `AOCS_OFF_COMPACT, 32'h0);
        chk("compact", rd, {14'h0, fl[1:0], dmd});
        $display("test %s done", nm);
    endtask : verify

    // ============================================================
    // scenarios
    task automatic t_regs();
        wb(1'b0, `AOCS_OFF_GUARD, 32'h0);
        chk("guard", rd, 32'h1);
        chk("st_rst", st, 8'h02);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, `AOCS_OFF_GUARD, 32'hc8);
        wb(1'b0, `AOCS_OFF_GUARD, 32'h0);
        chk("guard_sat", rd, 32'h64);
        wb(1'b1, `AOCS_OFF_GUARD, 32'h1);
        // low byte lane only: the high demand byte keeps its reset zero
        sel <= 4'h1;
        wb(1'b1, `AOCS_OFF_DEMAND, 32'h5678);
        sel <= 4'hf;
        wb(1'b0, `AOCS_OFF_DEMAND, 32'h0);
        chk("lane", rd, 32'h78);
        $display("test regs done");
    endtask : t_regs

    task automatic t_states();
        run(16'h1000, 3'h0, 1'b0);
        verify("on", 8'h04, 3'b000, 16'sh2ee0, 16'sh1400, 16'h1400);
        run(16'hfc00, 3'h0, 1'b0);
        verify("off", 8'h02, 3'b000, 16'sh2ee0, 16'sh0000, 16'h0000);
        run(16'hfc00, 3'h3, 1'b0);
        verify("nofield", 8'h01, 3'b001, 16'sh0000, 16'sh0000, 16'h0000);
        run(16'h0000, 3'h1, 1'b0);
        verify("noload", 8'h03, 3'b011, 16'sh01f4, 16'sh0000, 16'h0400);
        run(16'h0000, 3'h2, 1'b0);
        verify("reverse", 8'h06, 3'b011, -16'sd1001, 16'sh0000, 16'h0400);
    endtask : t_states

    // 52 counts short: beyond 1 percent guard, within 2 percent
    task automatic t_comply();
        run(16'h1000, 3'h4, 1'b0);
        verify("comply", 8'h05, 3'b011, 16'sh2ee0, 16'sh13cc, 16'h1400);
        wb(1'b1, `AOCS_OFF_GUARD, 32'h2);
        cycle();
        verify("guard", 8'h05, 3'b001, 16'sh2ee0, 16'sh13cc, 16'h1400);
        wb(1'b1, `AOCS_OFF_GUARD, 32'h1);
    endtask : t_comply

    // fault wins over all; status then holds without a new cycle
    task automatic t_fault();
        run(16'h1000, 3'h2, 1'b1);
        verify("fault", 8'h07, 3'b111, 16'sh0000, 16'sh0000, 16'h0000);
        dg <= 1'b0;
        mode <= 3'h0;
        repeat (6) @(posedge clk_i);
        chk("hold", st, 8'h07);
    endtask : t_fault

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ============================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_states();
        t_comply();
        t_fault();
        conclude();
    end
endmodule : tb_top
